// >>> common/tmcp_defines.vh
// Purpose: Shared constants of the sixteen-bit timer and capture core.
// Assumes: Included by bare name from every design file of the core.
// Notes:   Location codes are the low bits of the CPU byte address.
`ifndef TMCP_DEFINES_VH
`define TMCP_DEFINES_VH

// -------------------------------------------------------------------
// CPU byte locations
// -------------------------------------------------------------------
`define TMCP_LOC_CNT_LOW 3'h0
`define TMCP_LOC_CNT_HIGH 3'h1
`define TMCP_LOC_CAP_LOW 3'h2
`define TMCP_LOC_CAP_HIGH 3'h3
`define TMCP_LOC_CMPA_LOW 3'h4
`define TMCP_LOC_CMPA_HIGH 3'h5
`define TMCP_LOC_CMPB_LOW 3'h6
`define TMCP_LOC_CMPB_HIGH 3'h7

// -------------------------------------------------------------------
// Clock source select codes
// -------------------------------------------------------------------
`define TMCP_CS_STOP 3'h0
`define TMCP_CS_DIV1 3'h1
`define TMCP_CS_DIV8 3'h2
`define TMCP_CS_DIV64 3'h3
`define TMCP_CS_DIV256 3'h4
`define TMCP_CS_DIV1024 3'h5
`define TMCP_CS_EXT_FALL 3'h6
`define TMCP_CS_EXT_RISE 3'h7
`define TMCP_PRESCALE_W 10

// -------------------------------------------------------------------
// Waveform generation modes
// -------------------------------------------------------------------
`define TMCP_WGM_NORMAL 4'h0
`define TMCP_WGM_PC8 4'h1
`define TMCP_WGM_PC9 4'h2
`define TMCP_WGM_PC10 4'h3
`define TMCP_WGM_CTC_CMPA 4'h4
`define TMCP_WGM_FAST8 4'h5
`define TMCP_WGM_FAST9 4'h6
`define TMCP_WGM_FAST10 4'h7
`define TMCP_WGM_PFC_CAP 4'h8
`define TMCP_WGM_PFC_CMPA 4'h9
`define TMCP_WGM_PC_CAP 4'ha
`define TMCP_WGM_PC_CMPA 4'hb
`define TMCP_WGM_CTC_CAP 4'hc
`define TMCP_WGM_FAST_CAP 4'he
`define TMCP_WGM_FAST_CMPA 4'hf

// -------------------------------------------------------------------
// Count limits and reset values
// -------------------------------------------------------------------
`define TMCP_BOTTOM 16'h0000
`define TMCP_MAX 16'hffff
`define TMCP_TOP8 16'h00ff
`define TMCP_TOP9 16'h01ff
`define TMCP_TOP10 16'h03ff
`define TMCP_RST_WORD 16'h0000
`define TMCP_RST_BYTE 8'h00

`endif

// >>> core/tmcp_tick_gen.v
// Purpose: Builds the one-cycle timer tick from the selected clock source.
// Assumes: The external clock pin is asynchronous to clk.
// Notes:   The prescaler runs freely; a stopped select gives no tick.
`timescale 1ns/1ps
`include "tmcp_defines.vh"

module tmcp_tick_gen
(
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // Source selection.
   input wire [2:0] clock_source_select,
   // External clock pin, asynchronous.
   input wire ext_clock_pin,
   // One-cycle timer tick.
   output reg timer_tick
);

   reg [`TMCP_PRESCALE_W-1:0] presc_q; // Free-running prescaler.
   reg ext_s1_q; // First synchroniser stage.
   reg ext_s2_q; // Second synchroniser stage.
   reg ext_prev_q; // Delayed copy for edge detection.
   reg tick_d; // Next tick value.

   // ----------------------------------------------------------------
   // Prescaler and external pin synchroniser
   // ----------------------------------------------------------------
   // The first stage feeds only the second stage.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         presc_q <= {`TMCP_PRESCALE_W{1'b0}};
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end
      else
      begin
         presc_q <= presc_q + 1'b1;
         ext_s1_q <= ext_clock_pin;
         ext_s2_q <= ext_s1_q;
         ext_prev_q <= ext_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Tap selection
   // ----------------------------------------------------------------
   // Each tap fires once per wrap of its prescaler bits.
   always @*
   begin
      case (clock_source_select)
         `TMCP_CS_STOP: tick_d = 1'b0;
         `TMCP_CS_DIV1: tick_d = 1'b1;
         `TMCP_CS_DIV8: tick_d = &presc_q[2:0];
         `TMCP_CS_DIV64: tick_d = &presc_q[5:0];
         `TMCP_CS_DIV256: tick_d = &presc_q[7:0];
         `TMCP_CS_DIV1024: tick_d = &presc_q[9:0];
         `TMCP_CS_EXT_FALL: tick_d = ext_prev_q & ~ext_s2_q;
         `TMCP_CS_EXT_RISE: tick_d = ~ext_prev_q & ext_s2_q;
         default: tick_d = 1'b0;
      endcase
   end

   // Registered tick so the counter sees a clean pulse.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timer_tick <= 1'b0;
      end
      else
      begin
         timer_tick <= tick_d;
      end
   end

endmodule // tmcp_tick_gen

// >>> core/tmcp_core.v
// Purpose: Sixteen-bit up/down timer with input capture and byte access.
// Assumes: CPU strobes io_rd and io_wr are one-cycle pulses on clk.
// Notes:   Read data appears on io_rdata one cycle after the read strobe.
`timescale 1ns/1ps
`include "tmcp_defines.vh"

module tmcp_core
(
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // CPU byte port.
   input wire [2:0] io_addr,
   input wire io_rd,
   input wire io_wr,
   input wire [7:0] io_wdata,
   output reg [7:0] io_rdata,
   // Configuration.
   input wire [2:0] clock_source_select,
   input wire [3:0] waveform_gen_mode,
   input wire capture_edge_rising,
   input wire capture_from_comparator,
   input wire capture_irq_enable,
   input wire overflow_irq_enable,
   // Flag clears and interrupt service.
   input wire capture_flag_clear,
   input wire overflow_flag_clear,
   input wire capture_irq_ack,
   input wire overflow_irq_ack,
   // Asynchronous pins.
   input wire ext_clock_pin,
   input wire capture_pin,
   input wire comparator_output,
   // Status.
   output reg [15:0] timer_count,
   output reg count_down,
   output reg top_hit,
   output reg bottom_hit,
   output reg overflow_flag,
   output reg capture_flag,
   output reg overflow_irq,
   output reg capture_irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire timer_tick; // One-cycle tick from the clock select logic.
   reg [7:0] hold_q; // Shared high-byte holding register.
   reg [15:0] cap_q; // Capture register.
   reg [15:0] cmpa_q; // Compare value A.
   reg [15:0] cmpb_q; // Compare value B.
   reg [15:0] cnt_d; // Next counter value.
   reg dir_d; // Next direction, high for down.
   reg ovf_set; // Overflow event this cycle.
   reg [15:0] top_val; // Sequence maximum for the mode.
   reg dual_slope; // Mode counts up then down.
   reg fast_mode; // Single slope, overflow at TOP.
   reg cap_is_top; // Capture register defines TOP.
   reg icp_s1_q; // Capture pin first stage.
   reg icp_s2_q; // Capture pin second stage.
   reg aco_s1_q; // Comparator first stage.
   reg aco_s2_q; // Comparator second stage.
   reg src_prev_q; // Last selected capture source level.
   wire src_now; // Selected capture source level.
   wire cap_edge; // Matching edge seen.
   wire cap_trig; // Capture taken this cycle.
   wire wr_cnt_low; // CPU writes counter low byte.
   wire cap_flag_d; // Next capture flag.
   wire ovf_flag_d; // Next overflow flag.

   assign wr_cnt_low = io_wr && (io_addr == `TMCP_LOC_CNT_LOW);

   // ----------------------------------------------------------------
   // Timer tick generation
   // ----------------------------------------------------------------
   tmcp_tick_gen u_tick
   (
      .clk(clk),
      .reset_n(reset_n),
      .clock_source_select(clock_source_select),
      .ext_clock_pin(ext_clock_pin),
      .timer_tick(timer_tick)
   );

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // The four mode bits fix TOP, slope and overflow point.
   always @*
   begin
      top_val = `TMCP_MAX;
      dual_slope = 1'b0;
      fast_mode = 1'b0;
      cap_is_top = 1'b0;
      case (waveform_gen_mode)
         `TMCP_WGM_NORMAL: top_val = `TMCP_MAX;
         `TMCP_WGM_PC8:
         begin
            top_val = `TMCP_TOP8;
            dual_slope = 1'b1;
         end
         `TMCP_WGM_PC9:
         begin
            top_val = `TMCP_TOP9;
            dual_slope = 1'b1;
         end
         `TMCP_WGM_PC10:
         begin
            top_val = `TMCP_TOP10;
            dual_slope = 1'b1;
         end
         `TMCP_WGM_CTC_CMPA: top_val = cmpa_q;
         `TMCP_WGM_FAST8:
         begin
            top_val = `TMCP_TOP8;
            fast_mode = 1'b1;
         end
         `TMCP_WGM_FAST9:
         begin
            top_val = `TMCP_TOP9;
            fast_mode = 1'b1;
         end
         `TMCP_WGM_FAST10:
         begin
            top_val = `TMCP_TOP10;
            fast_mode = 1'b1;
         end
         `TMCP_WGM_PFC_CAP, `TMCP_WGM_PC_CAP:
         begin
            top_val = cap_q;
            dual_slope = 1'b1;
            cap_is_top = 1'b1;
         end
         `TMCP_WGM_PFC_CMPA, `TMCP_WGM_PC_CMPA:
         begin
            top_val = cmpa_q;
            dual_slope = 1'b1;
         end
         `TMCP_WGM_CTC_CAP:
         begin
            top_val = cap_q;
            cap_is_top = 1'b1;
         end
         `TMCP_WGM_FAST_CAP:
         begin
            top_val = cap_q;
            fast_mode = 1'b1;
            cap_is_top = 1'b1;
         end
         `TMCP_WGM_FAST_CMPA:
         begin
            top_val = cmpa_q;
            fast_mode = 1'b1;
         end
         default: top_val = `TMCP_MAX; // Reserved mode counts like normal.
      endcase
   end

   // ----------------------------------------------------------------
   // Counter next state
   // ----------------------------------------------------------------
   // A CPU low-byte write wins over any tick in the same cycle.
   always @*
   begin
      cnt_d = timer_count;
      dir_d = count_down;
      ovf_set = 1'b0;
      if (wr_cnt_low)
      begin
         cnt_d = {hold_q, io_wdata};
      end
      else if (timer_tick)
      begin
         if (dual_slope)
         begin
            if (!count_down)
            begin
               if (timer_count >= top_val)
               begin
                  dir_d = 1'b1;
                  cnt_d = timer_count - 1'b1;
               end
               else
               begin
                  cnt_d = timer_count + 1'b1;
               end
            end
            else if (timer_count == `TMCP_BOTTOM)
            begin
               dir_d = 1'b0;
               cnt_d = timer_count + 1'b1;
               ovf_set = 1'b1;
            end
            else
            begin
               cnt_d = timer_count - 1'b1;
            end
         end
         else
         begin
            dir_d = 1'b0;
            if (timer_count == top_val)
            begin
               cnt_d = `TMCP_BOTTOM;
            end
            else
            begin
               cnt_d = timer_count + 1'b1;
            end
            // Fast modes flag at TOP; normal and clear modes at MAX.
            ovf_set = fast_mode ? (timer_count == top_val)
                                : (timer_count == `TMCP_MAX);
         end
      end
   end

   // Counter, direction and TOP/BOTTOM indications.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         timer_count <= `TMCP_RST_WORD;
         count_down <= 1'b0;
         top_hit <= 1'b0;
         bottom_hit <= 1'b0;
      end
      else
      begin
         timer_count <= cnt_d;
         count_down <= dir_d;
         top_hit <= (cnt_d == top_val);
         bottom_hit <= (cnt_d == `TMCP_BOTTOM);
      end
   end

   // ----------------------------------------------------------------
   // Capture source synchronisers and edge detect
   // ----------------------------------------------------------------
   // Both sources are synchronised; switching source can itself
   // look like an edge, which software must clear afterwards.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         icp_s1_q <= 1'b0;
         icp_s2_q <= 1'b0;
         aco_s1_q <= 1'b0;
         aco_s2_q <= 1'b0;
         src_prev_q <= 1'b0;
      end
      else
      begin
         icp_s1_q <= capture_pin;
         icp_s2_q <= icp_s1_q;
         aco_s1_q <= comparator_output;
         aco_s2_q <= aco_s1_q;
         src_prev_q <= src_now;
      end
   end

   assign src_now = capture_from_comparator ? aco_s2_q : icp_s2_q;
   assign cap_edge = capture_edge_rising ? (src_now & ~src_prev_q)
                                         : (~src_now & src_prev_q);
   // Capture is off while the capture register sets TOP.
   assign cap_trig = cap_edge & ~cap_is_top;

   // ----------------------------------------------------------------
   // Holding register, capture and compare registers
   // ----------------------------------------------------------------
   // Every high-location write lands in the holding register only.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         hold_q <= `TMCP_RST_BYTE;
         cap_q <= `TMCP_RST_WORD;
         cmpa_q <= `TMCP_RST_WORD;
         cmpb_q <= `TMCP_RST_WORD;
      end
      else
      begin
         if (io_wr)
         begin
            case (io_addr)
               `TMCP_LOC_CNT_HIGH, `TMCP_LOC_CAP_HIGH,
               `TMCP_LOC_CMPA_HIGH, `TMCP_LOC_CMPB_HIGH:
                  hold_q <= io_wdata;
               `TMCP_LOC_CAP_LOW:
                  if (cap_is_top)
                  begin
                     cap_q <= {hold_q, io_wdata};
                  end
               `TMCP_LOC_CMPA_LOW: cmpa_q <= {hold_q, io_wdata};
               `TMCP_LOC_CMPB_LOW: cmpb_q <= {hold_q, io_wdata};
               default: hold_q <= hold_q;
            endcase
         end
         else if (io_rd)
         begin
            if (io_addr == `TMCP_LOC_CNT_LOW)
            begin
               hold_q <= timer_count[15:8];
            end
            else if (io_addr == `TMCP_LOC_CAP_LOW)
            begin
               hold_q <= cap_q[15:8];
            end
         end
         if (cap_trig)
         begin
            cap_q <= timer_count;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Compare locations return both bytes directly.
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         io_rdata <= `TMCP_RST_BYTE;
      end
      else if (io_rd)
      begin
         case (io_addr)
            `TMCP_LOC_CNT_LOW: io_rdata <= timer_count[7:0];
            `TMCP_LOC_CNT_HIGH: io_rdata <= hold_q;
            `TMCP_LOC_CAP_LOW: io_rdata <= cap_q[7:0];
            `TMCP_LOC_CAP_HIGH: io_rdata <= hold_q;
            `TMCP_LOC_CMPA_LOW: io_rdata <= cmpa_q[7:0];
            `TMCP_LOC_CMPA_HIGH: io_rdata <= cmpa_q[15:8];
            `TMCP_LOC_CMPB_LOW: io_rdata <= cmpb_q[7:0];
            `TMCP_LOC_CMPB_HIGH: io_rdata <= cmpb_q[15:8];
            default: io_rdata <= `TMCP_RST_BYTE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flags and interrupt requests
   // ----------------------------------------------------------------
   // A new event in the clearing cycle keeps the flag set.
   assign cap_flag_d = cap_trig
      | (capture_flag & ~capture_flag_clear & ~capture_irq_ack);
   assign ovf_flag_d = ovf_set
      | (overflow_flag & ~overflow_flag_clear & ~overflow_irq_ack);

   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         capture_flag <= 1'b0;
         overflow_flag <= 1'b0;
         capture_irq <= 1'b0;
         overflow_irq <= 1'b0;
      end
      else
      begin
         capture_flag <= cap_flag_d;
         overflow_flag <= ovf_flag_d;
         capture_irq <= cap_flag_d & capture_irq_enable;
         overflow_irq <= ovf_flag_d & overflow_irq_enable;
      end
   end

endmodule // tmcp_core

// >>> dv/tmcp_core_asserts.sv
// Purpose: Concurrent checks on the ports of the timer and capture core.
// Assumes: One clock domain; reset_n is asynchronous and active low.
// Notes:   Bound to tmcp_core from the testbench top file.
`timescale 1ns/1ps

module tmcp_core_asserts
(
   // Clock and reset.
   input wire clk,
   input wire reset_n,
   // CPU byte port.
   input wire [2:0] io_addr,
   input wire io_rd,
   input wire io_wr,
   input wire [7:0] io_wdata,
   input wire [7:0] io_rdata,
   // Configuration and service.
   input wire [2:0] clock_source_select,
   input wire [3:0] waveform_gen_mode,
   input wire capture_irq_enable,
   input wire overflow_irq_enable,
   input wire capture_flag_clear,
   input wire capture_irq_ack,
   // Status.
   input wire [15:0] timer_count,
   input wire top_hit,
   input wire bottom_hit,
   input wire overflow_flag,
   input wire capture_flag,
   input wire overflow_irq,
   input wire capture_irq
);
   // ----------
   // Clocking
   // ----------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Counter high write, then low write.
   sequence s_cnt_pair_wr;
      (io_wr && io_addr == 3'h1) ##1 (io_wr && io_addr == 3'h0);
   endsequence
   // Counter low read, then high read.
   sequence s_cnt_pair_rd;
      (io_rd && !io_wr && io_addr == 3'h0) ##1 (io_rd && !io_wr && io_addr == 3'h1);
   endsequence
   // Three cycles with no clock source and no CPU write.
   sequence s_stopped;
      (clock_source_select == 3'h0 && !io_wr) [*3];
   endsequence

   // ----------
   // Properties
   // ----------
   property p_stop_hold;
      s_stopped |=> $stable(timer_count);
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("counter moved with no clock source");
   property p_cnt_write;
      s_cnt_pair_wr |=> timer_count == {$past(io_wdata, 2), $past(io_wdata)};
   endproperty
   a_cnt_write: assert property (p_cnt_write)
      else $error("two byte counter write not loaded");
   property p_low_wins;
      (io_wr && io_addr == 3'h0) |=> timer_count[7:0] == $past(io_wdata);
   endproperty
   a_low_wins: assert property (p_low_wins)
      else $error("counter low write lost");
   property p_rd_pair;
      s_cnt_pair_rd |=> {8'h00, io_rdata} == ($past(timer_count, 2) >> 8);
   endproperty
   a_rd_pair: assert property (p_rd_pair)
      else $error("high byte read not latched by low read");
   property p_cap_irq;
      capture_irq == (capture_flag && $past(capture_irq_enable));
   endproperty
   a_cap_irq: assert property (p_cap_irq)
      else $error("capture interrupt disagrees with flag");
   property p_ovf_irq;
      overflow_irq == (overflow_flag && $past(overflow_irq_enable));
   endproperty
   a_ovf_irq: assert property (p_ovf_irq)
      else $error("overflow interrupt disagrees with flag");
   property p_flag_fall;
      $fell(capture_flag) |-> $past(capture_flag_clear) || $past(capture_irq_ack);
   endproperty
   a_flag_fall: assert property (p_flag_fall)
      else $error("capture flag fell without clear");
   property p_bottom;
      $past(reset_n) |-> bottom_hit == (timer_count == 16'h0000);
   endproperty
   a_bottom: assert property (p_bottom)
      else $error("bottom indication wrong");
   property p_top;
      ($past(reset_n) && waveform_gen_mode == 4'h0 && $past(waveform_gen_mode) == 4'h0)
         |-> top_hit == (timer_count == 16'hffff);
   endproperty
   a_top: assert property (p_top)
      else $error("top indication wrong in normal mode");
   property p_ovf_point;
      ($rose(overflow_flag) && $past(waveform_gen_mode) == 4'h0)
         |-> $past(timer_count) == 16'hffff;
   endproperty
   a_ovf_point: assert property (p_ovf_point)
      else $error("overflow flag set away from maximum");
endmodule // tmcp_core_asserts

// >>> dv/tmcp_cpu_model.sv
// Purpose: Behavioural CPU that reaches the core over the byte port.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   Single thread, so no interrupt can split a two-byte access.
`timescale 1ns/1ps

module tmcp_cpu_model
(
   // Clock.
   input wire clk,
   // Byte port toward the core.
   output reg [2:0] io_addr,
   output reg io_rd,
   output reg io_wr,
   output reg [7:0] io_wdata,
   input wire [7:0] io_rdata
);
   // Idle bus at time zero.
   initial
   begin
      {io_addr, io_rd, io_wr, io_wdata} = 13'h0;
   end
   // One byte write, taken at the next edge.
   task wr(input logic [2:0] a, input logic [7:0] d);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      io_rd = 1'b0;
      @(posedge clk);
      #1;
   endtask
   // One byte read; data is registered at the taking edge.
   task rd(input logic [2:0] a, output logic [7:0] d);
      io_addr = a;
      io_rd = 1'b1;
      io_wr = 1'b0;
      @(posedge clk);
      #1;
      d = io_rdata;
   endtask
   // Release the bus; inverted stale data cannot pass.
   task idle;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = ~io_wdata;
      @(posedge clk);
      #1;
   endtask
   // Two-byte write: high location first, low second, uninterrupted.
   task wr16(input logic [2:0] lo, input logic [15:0] v);
      wr(lo + 3'h1, v[15:8]);
      wr(lo, v[7:0]);
      idle;
   endtask
   // Two-byte read: low location first, high second, uninterrupted.
   task rd16(input logic [2:0] lo, output logic [15:0] v);
      rd(lo, v[7:0]);
      rd(lo + 3'h1, v[15:8]);
      idle;
   endtask
endmodule // tmcp_cpu_model

// >>> dv/tmcp_core_test.sv
// Purpose: Self-checking bench for the timer and capture core.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Table loop first, then hand-written awkward cases.
`timescale 1ns/1ps
`include "tmcp_defines.vh"

module tmcp_core_test;
   // Clock, reset and plain control inputs.
   logic clk, reset_n, cap_rise, cap_cmp, cap_ie, ovf_ie, cap_clr, ovf_clr, cap_ack, ovf_ack;
   logic ext_pin, cap_pin, cmp_out;
   logic [2:0] cs_sel, io_addr;
   logic [3:0] wgm;
   // CPU port and status from the core.
   logic io_rd, io_wr, top_hit, bottom_hit, ovf_flag, cap_flag, ovf_irq, cap_irq, cnt_dn;
   logic [7:0] io_wdata, io_rdata;
   logic [15:0] timer_count, got;
   int error_cnt, total_checks, i, m;
   // Rows: low-byte location, then value written and expected.
   logic [18:0] rows [0:3] = '{{3'h0, 16'h01ff}, {3'h0, 16'hffff}, {3'h4, 16'h1234},
      {3'h6, 16'hedcb}};
   logic [3:0] md [0:5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
   logic [15:0] tp [0:5] = '{`TMCP_TOP8, `TMCP_TOP9, `TMCP_TOP10, `TMCP_TOP8, `TMCP_TOP9,
      `TMCP_TOP10};

   tmcp_cpu_model cpu (.clk, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata);
   tmcp_core dut (.clk, .reset_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
      .clock_source_select(cs_sel), .waveform_gen_mode(wgm), .capture_edge_rising(cap_rise),
      .capture_from_comparator(cap_cmp), .capture_irq_enable(cap_ie),
      .overflow_irq_enable(ovf_ie), .capture_flag_clear(cap_clr),
      .overflow_flag_clear(ovf_clr), .capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack),
      .ext_clock_pin(ext_pin), .capture_pin(cap_pin), .comparator_output(cmp_out),
      .timer_count, .count_down(cnt_dn), .top_hit, .bottom_hit, .overflow_flag(ovf_flag),
      .capture_flag(cap_flag), .overflow_irq(ovf_irq), .capture_irq(cap_irq));

   // 100 ns clock.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Advance n edges, landing 1 ns after the last.
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Compare one value and count it.
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Print counts and verdict, then stop.
   task close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Watchdog well beyond the expected run.
   initial
   begin
      #2000000;
      error_cnt++;
      close_out;
   end

   // ----------
   // Main sequence
   // ----------
   initial
   begin
      {cap_clr, ovf_clr, cap_ack, ovf_ack, ext_pin, cap_pin, cmp_out, cap_cmp} = 8'h00;
      {cap_rise, cap_ie, ovf_ie} = 3'h7;
      cs_sel = `TMCP_CS_STOP;
      wgm = `TMCP_WGM_NORMAL;
      reset_n = 1'b0;
      step(5);
      reset_n = 1'b1;
      step(2);
      chk("count", 16'h0000, timer_count);
      chk("bottom", 16'h0001, {15'h0, bottom_hit});
      chk("flags", 16'h0000, {14'h0, cap_flag, ovf_flag});
      // Table: two-byte write then two-byte read of the counter and both compare registers.
      for (i = 0; i < 4; i++)
      begin
         cpu.wr16(rows[i][18:16], rows[i][15:0]);
         cpu.rd16(rows[i][18:16], got);
         chk("readback", rows[i][15:0], got);
      end
      // One held high byte shared by two low writes.
      cpu.wr(3'h1, 8'h3c);
      cpu.wr(3'h0, 8'h11);
      cpu.wr(3'h4, 8'h22);
      cpu.idle;
      cpu.rd16(3'h0, got);
      chk("count", 16'h3c11, got);
      cpu.rd16(3'h4, got);
      chk("cmp_a", 16'h3c22, got);
      // A compare read must leave the held byte alone.
      cpu.wr16(3'h6, 16'h7799);
      cpu.rd16(3'h0, got);
      cpu.rd16(3'h6, got);
      chk("cmp_b", 16'h7799, got);
      cpu.rd(3'h1, got[7:0]);
      cpu.idle;
      chk("held", 16'h003c, {8'h00, got[7:0]});
      step(6);
      chk("stopped", 16'h3c11, timer_count);
      // Wrap from the maximum sets the overflow flag.
      cpu.wr16(3'h0, 16'hfffd);
      cs_sel = `TMCP_CS_DIV1;
      for (i = 0; i < 20 && ovf_flag !== 1'b1; i++)
         step(1);
      chk("wrap", 16'h0000, timer_count);
      chk("ovf_irq", 16'h0001, {15'h0, ovf_irq});
      // CPU write while counting wins over the tick.
      cpu.wr(3'h1, 8'h12);
      cpu.wr(3'h0, 8'h34);
      chk("write_wins", 16'h1234, timer_count);
      cpu.idle;
      ovf_ack = 1'b1;
      step(1);
      ovf_ack = 1'b0;
      chk("ovf_ack", 16'h0000, {15'h0, ovf_flag});
      cs_sel = `TMCP_CS_STOP;
      step(3);
      // Every 8-, 9- and 10-bit mode reaches its own top.
      for (m = 0; m < 6; m++)
      begin
         wgm = md[m];
         cpu.wr16(3'h0, 16'h0000);
         cs_sel = `TMCP_CS_DIV1;
         for (i = 0; i < 1100 && top_hit !== 1'b1; i++)
            step(1);
         chk("top", tp[m], timer_count);
         cs_sel = `TMCP_CS_STOP;
         step(3);
         chk("dir", {15'h0, m < 3}, {15'h0, cnt_dn});
      end
      wgm = `TMCP_WGM_NORMAL;
      // External rising clock: three pin edges, three counts.
      cs_sel = `TMCP_CS_EXT_RISE;
      cpu.wr16(3'h0, 16'h0000);
      repeat (3)
      begin
         ext_pin = 1'b1;
         step(6);
         ext_pin = 1'b0;
         step(6);
      end
      chk("ext", 16'h0003, timer_count);
      cs_sel = `TMCP_CS_STOP;
      // Rising pin edge captures the stopped count.
      cpu.wr16(3'h0, 16'h4321);
      cap_pin = 1'b1;
      for (i = 0; i < 8 && cap_flag !== 1'b1; i++)
         step(1);
      chk("cap_irq", 16'h0001, {15'h0, cap_irq});
      cpu.rd16(3'h2, got);
      chk("capture", 16'h4321, got);
      cap_clr = 1'b1;
      step(1);
      cap_clr = 1'b0;
      chk("cap_clr", 16'h0000, {15'h0, cap_flag});
      cap_pin = 1'b0;
      step(6);
      chk("no_fall", 16'h0000, {15'h0, cap_flag});
      // Comparator source; a source change may capture, so clear after it.
      cap_cmp = 1'b1;
      step(6);
      cap_clr = 1'b1;
      step(1);
      cap_clr = 1'b0;
      cpu.wr16(3'h0, 16'h0abc);
      cmp_out = 1'b1;
      step(6);
      cpu.rd16(3'h2, got);
      chk("cmp_cap", 16'h0abc, got);
      cap_ack = 1'b1;
      step(1);
      cap_ack = 1'b0;
      chk("cap_ack", 16'h0000, {15'h0, cap_flag});
      cap_rise = 1'b0;
      cmp_out = 1'b0;
      step(6);
      chk("fall", 16'h0001, {15'h0, cap_flag});
      // Reset in mid-run clears the count.
      reset_n = 1'b0;
      step(2);
      reset_n = 1'b1;
      step(2);
      chk("rst_count", 16'h0000, timer_count);
      close_out;
   end
endmodule // tmcp_core_test

bind tmcp_core tmcp_core_asserts chk_i (.clk, .reset_n, .io_addr, .io_rd, .io_wr, .io_wdata,
   .io_rdata, .clock_source_select, .waveform_gen_mode, .capture_irq_enable,
   .overflow_irq_enable, .capture_flag_clear, .capture_irq_ack, .timer_count, .top_hit,
   .bottom_hit, .overflow_flag, .capture_flag, .overflow_irq, .capture_irq);
